// ===== include/sai_pkg.sv
// Package: constants, types and helpers of the serial audio input block
package sai_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_PORTS  = 9;   // input data lines and clock pairs
  localparam int unsigned NUM_FIXED  = 3;   // pairs always on the input side
  localparam int unsigned NUM_ASSIGN = 6;   // pairs steered by the pad mux
  localparam int unsigned ADDR_W     = 18;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned SAMPLE_W   = 24;
  localparam int unsigned DEJIT_W    = 6;
  localparam int unsigned PORT_W     = 4;
  localparam int unsigned CHAN_W     = 5;

  // ==========================================================================
  // Register indices (byte address is four times the index) and resets
  localparam logic [15:0]        REG_MODE0_IDX  = 16'hE000;
  localparam logic [15:0]        REG_DEJIT_IDX  = 16'hE221;
  localparam logic [15:0]        REG_PADMUX_IDX = 16'hE240;
  localparam logic [15:0]        REG_STATUS_IDX = 16'hE250;
  localparam logic [DATA_W-1:0]  MODE_RST       = 16'h3C00;
  localparam logic [DEJIT_W-1:0] DEJIT_RST      = 6'h08;
  localparam logic [DEJIT_W-1:0] DEJIT_BYPASS   = 6'h00;
  localparam logic [NUM_ASSIGN-1:0] PADMUX_RST  = 6'h00;

  // ==========================================================================
  // Timing
  localparam int unsigned CORE_CLK_PERIOD_NS = 5;
  localparam int unsigned CORE_CLK_HZ        = 1000000000 / CORE_CLK_PERIOD_NS;
  localparam int unsigned BCLK_MAX_MHZ       = 25;
  localparam int unsigned BCLK_MAX_HZ        = BCLK_MAX_MHZ * 1000000;
  localparam int unsigned BASE_FS_HZ         = 48000;

  // ==========================================================================
  // Mode word fields
  typedef enum logic [1:0] {
    SAI_WL_24   = 2'h0,
    SAI_WL_20   = 2'h1,
    SAI_WL_16   = 2'h2,
    SAI_WL_FLEX = 2'h3
  } sai_wl_e;

  typedef enum logic [2:0] {
    SAI_MSB_I2S = 3'h0,
    SAI_MSB_LJ  = 3'h1,
    SAI_MSB_D8  = 3'h2,
    SAI_MSB_D12 = 3'h3,
    SAI_MSB_D16 = 3'h4
  } sai_msb_e;

  typedef enum logic [2:0] {
    SAI_TDM2   = 3'h0,
    SAI_TDM4   = 3'h1,
    SAI_TDM8   = 3'h2,
    SAI_TDM16  = 3'h3,
    SAI_PACKED = 3'h4
  } sai_tdm_e;

  localparam logic [3:0] DOM_LAST_SLAVE = 4'h8;
  localparam logic [3:0] DOM_MST_BASE   = 4'h9;
  localparam logic [3:0] DOM_MST_DOUBLE = 4'hA;
  localparam logic [3:0] DOM_MST_QUAD   = 4'hB;

  typedef struct packed {
    logic     clk_oe;
    logic     pulse_sync;
    logic [3:0] domain;
    logic     bclk_pos;
    logic     lrclk_pos;
    sai_wl_e  wl;
    sai_msb_e msb;
    sai_tdm_e tdm;
  } sai_mode_s;

  typedef struct packed {
    logic [PORT_W-1:0]   port;
    logic [CHAN_W-1:0]   chan;
    logic [SAMPLE_W-1:0] data;
  } sai_sample_s;

  // ==========================================================================
  // Helpers
  function automatic sai_mode_s mode_reset(input logic [PORT_W-1:0] p);
    sai_mode_s m;
    m        = sai_mode_s'(MODE_RST);
    m.domain = p;
    return m;
  endfunction : mode_reset

  function automatic logic [9:0] frame_bits(input sai_tdm_e t);
    case (t)
      SAI_TDM4:  return 10'h080;
      SAI_TDM8:  return 10'h100;
      SAI_TDM16: return 10'h200;
      default:   return 10'h040;
    endcase
  endfunction : frame_bits

  function automatic logic [CHAN_W-1:0] max_chan(input sai_tdm_e t);
    case (t)
      SAI_TDM4, SAI_PACKED: return 5'h04;
      SAI_TDM8:             return 5'h08;
      SAI_TDM16:            return 5'h10;
      default:              return 5'h02;
    endcase
  endfunction : max_chan

  function automatic logic [4:0] slot_last(input sai_tdm_e t);
    return (t == SAI_PACKED) ? 5'h0F : 5'h1F;
  endfunction : slot_last

  function automatic logic [4:0] word_len(input sai_wl_e w);
    case (w)
      SAI_WL_20: return 5'h14;
      SAI_WL_16: return 5'h10;
      default:   return 5'h18;
    endcase
  endfunction : word_len

  function automatic logic [4:0] msb_delay(input sai_msb_e m);
    case (m)
      SAI_MSB_LJ:  return 5'h00;
      SAI_MSB_D8:  return 5'h08;
      SAI_MSB_D12: return 5'h0C;
      SAI_MSB_D16: return 5'h10;
      default:     return 5'h01;
    endcase
  endfunction : msb_delay

  function automatic logic [2:0] rate_mult(input logic [3:0] d);
    case (d)
      DOM_MST_DOUBLE: return 3'h2;
      DOM_MST_QUAD:   return 3'h4;
      default:        return 3'h1;
    endcase
  endfunction : rate_mult

  function automatic logic [ADDR_W-1:0] reg_byte(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : reg_byte

endpackage : sai_pkg

// ===== hdl/sai_rx_top.sv
// Serial audio input ports with dejitter, clock pad mux and domain selector
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module sai_rx_top
  import sai_pkg::*;
#(
  parameter int unsigned CLK_HZ  = sai_pkg::CORE_CLK_HZ,
  parameter int unsigned BASE_FS = sai_pkg::BASE_FS_HZ
) (
  // Clock and reset
  input  wire logic                           core_clk_i,
  input  wire logic                           sys_rst_i,
  // Register port
  input  wire logic [sai_pkg::ADDR_W-1:0]     reg_addr_i,
  input  wire logic [sai_pkg::DATA_W-1:0]     reg_wdata_i,
  input  wire logic                           reg_wr_i,
  input  wire logic                           reg_rd_i,
  output logic      [sai_pkg::DATA_W-1:0]     reg_rdata_o,
  // Serial data pins
  input  wire logic [sai_pkg::NUM_PORTS-1:0]  serial_audio_input_line_i,
  // Clock pin pairs, three signals per pin
  input  wire logic [sai_pkg::NUM_PORTS-1:0]  bclk_pin_i,
  input  wire logic [sai_pkg::NUM_PORTS-1:0]  lrclk_pin_i,
  output logic      [sai_pkg::NUM_PORTS-1:0]  bclk_pin_o,
  output logic      [sai_pkg::NUM_PORTS-1:0]  lrclk_pin_o,
  output logic      [sai_pkg::NUM_PORTS-1:0]  bclk_pin_oe_n_o,
  output logic      [sai_pkg::NUM_PORTS-1:0]  lrclk_pin_oe_n_o,
  // Pairs handed to the output side
  output logic      [sai_pkg::NUM_ASSIGN-1:0] clk_pad_out_side_o,
  // Sample stream
  output sai_pkg::sai_sample_s                sample_o,
  output logic                                sample_valid_o
);

  // ==========================================================================
  // Declarations
  typedef logic [NUM_PORTS-1:0] sai_vec_t;

  sai_mode_s            mode_ff [NUM_PORTS];
  logic [DEJIT_W-1:0]   dejit_ff;
  logic [NUM_ASSIGN-1:0] padmux_ff;
  logic [DATA_W-1:0]    rdata_ff;
  sai_vec_t             bclk_s1_ff, bclk_s2_ff, lr_s1_ff, lr_s2_ff, sd_s1_ff, sd_s2_ff;
  sai_vec_t             lr_filt_ff;
  logic [DEJIT_W-1:0]   jit_cnt_ff [NUM_PORTS];
  logic [31:0]          acc_ff [NUM_PORTS];
  logic [9:0]           gbit_ff [NUM_PORTS];
  sai_vec_t             gbclk_ff, glr_ff;
  sai_vec_t             e_prev_ff, lr_last_ff, framed_ff, pend_ff;
  logic [4:0]           pos_ff [NUM_PORTS];
  logic [CHAN_W-1:0]    chan_ff [NUM_PORTS];
  logic [SAMPLE_W-1:0]  shift_ff [NUM_PORTS];
  logic [SAMPLE_W-1:0]  word_ff [NUM_PORTS];
  logic [CHAN_W-1:0]    wchan_ff [NUM_PORTS];
  logic [PORT_W-1:0]    rr_ff;
  sai_vec_t             bpin_ff, lpin_ff, boe_n_ff, loe_n_ff;
  sai_sample_s          sample_ff;
  logic                 svalid_ff;

  sai_vec_t             avail, is_master, gen_ok, mode_wr;
  logic [31:0]          inc [NUM_PORTS];
  sai_vec_t             e_now, lr_now, rise, fstart, fhalf;
  logic [4:0]           nxt_pos [NUM_PORTS];
  logic [CHAN_W-1:0]    nxt_chan [NUM_PORTS];
  logic [SAMPLE_W-1:0]  nxt_shift [NUM_PORTS];
  sai_vec_t             in_win, last_bit;
  logic                 dejit_wr, padmux_wr;

  // ==========================================================================
  // Register port
  // Write decode on word-aligned byte addresses
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      mode_wr[p] = reg_wr_i && (reg_addr_i == reg_byte(REG_MODE0_IDX + 16'(p)));
    end
    dejit_wr  = reg_wr_i && (reg_addr_i == reg_byte(REG_DEJIT_IDX));
    padmux_wr = reg_wr_i && (reg_addr_i == reg_byte(REG_PADMUX_IDX));
  end

  // Port mode words, default domain equals port index
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        mode_ff[p] <= mode_reset(PORT_W'(p));
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (mode_wr[p]) begin
          mode_ff[p] <= sai_mode_s'(reg_wdata_i);
        end
      end
    end
  end

  // Dejitter window and pad mux; upper bits are not stored
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dejit_ff  <= DEJIT_RST;
      padmux_ff <= PADMUX_RST;
    end else begin
      if (dejit_wr) begin
        dejit_ff <= reg_wdata_i[DEJIT_W-1:0];
      end
      if (padmux_wr) begin
        padmux_ff <= reg_wdata_i[NUM_ASSIGN-1:0];
      end
    end
  end

  // Read data, valid only in the cycle after the read strobe
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_ff <= '0;
    end else if (reg_rd_i) begin
      rdata_ff <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (reg_addr_i == reg_byte(REG_MODE0_IDX + 16'(p))) begin
          rdata_ff <= mode_ff[p];
        end
      end
      if (reg_addr_i == reg_byte(REG_DEJIT_IDX)) begin
        rdata_ff <= {{(DATA_W-DEJIT_W){1'b0}}, dejit_ff};
      end
      if (reg_addr_i == reg_byte(REG_PADMUX_IDX)) begin
        rdata_ff <= {{(DATA_W-NUM_ASSIGN){1'b0}}, padmux_ff};
      end
      if (reg_addr_i == reg_byte(REG_STATUS_IDX)) begin
        rdata_ff <= {{(DATA_W-NUM_PORTS){1'b0}}, framed_ff};
      end
    end else begin
      rdata_ff <= '0;
    end
  end

  // ==========================================================================
  // Pin synchronisers and frame clock dejitter
  // Two flops on every pin input
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bclk_s1_ff <= '0;
      bclk_s2_ff <= '0;
      lr_s1_ff   <= '0;
      lr_s2_ff   <= '0;
      sd_s1_ff   <= '0;
      sd_s2_ff   <= '0;
    end else begin
      bclk_s1_ff <= bclk_pin_i;
      bclk_s2_ff <= bclk_s1_ff;
      lr_s1_ff   <= lrclk_pin_i;
      lr_s2_ff   <= lr_s1_ff;
      sd_s1_ff   <= serial_audio_input_line_i;
      sd_s2_ff   <= sd_s1_ff;
    end
  end

  // A frame clock change is accepted only after standing for the window.
  // The filter delays the frame clock by the window; at the fastest bit
  // clocks a wide window can push frame detection late by up to eight bits.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lr_filt_ff <= '0;
      for (int d = 0; d < NUM_PORTS; d++) begin
        jit_cnt_ff[d] <= '0;
      end
    end else begin
      for (int d = 0; d < NUM_PORTS; d++) begin
        if (dejit_ff == DEJIT_BYPASS) begin
          lr_filt_ff[d] <= lr_s2_ff[d];
          jit_cnt_ff[d] <= '0;
        end else if (lr_s2_ff[d] == lr_filt_ff[d]) begin
          jit_cnt_ff[d] <= '0;
        end else if (jit_cnt_ff[d] + 6'h01 >= dejit_ff) begin
          lr_filt_ff[d] <= lr_s2_ff[d];
          jit_cnt_ff[d] <= '0;
        end else begin
          jit_cnt_ff[d] <= jit_cnt_ff[d] + 6'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Domain availability and master clock generation
  // Pairs 0..2 fixed to input side, 3..8 by pad mux bits 0..5
  always_comb begin
    for (int d = 0; d < NUM_PORTS; d++) begin
      if (d < NUM_FIXED) begin
        avail[d] = 1'b1;
      end else begin
        avail[d] = !padmux_ff[d - NUM_FIXED];
      end
    end
  end

  // Master needs the enable and a master code; no clock for a rate above 25 MHz
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      is_master[p] = mode_ff[p].clk_oe && (mode_ff[p].domain >= DOM_MST_BASE)
                     && (mode_ff[p].domain <= DOM_MST_QUAD);
      inc[p]       = 32'(BASE_FS * 32'(rate_mult(mode_ff[p].domain))
                         * 32'(frame_bits(mode_ff[p].tdm)));
      gen_ok[p]    = is_master[p] && avail[p] && (inc[p] <= BCLK_MAX_HZ);
    end
  end

  // Phase accumulator toggles the bit clock at twice its rate
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gbclk_ff <= '0;
      glr_ff   <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        acc_ff[p]  <= '0;
        gbit_ff[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!gen_ok[p]) begin
          acc_ff[p]  <= '0;
          gbit_ff[p] <= '0;
          gbclk_ff[p] <= 1'b0;
          glr_ff[p]  <= ~mode_ff[p].lrclk_pos;
        end else if (acc_ff[p] + {inc[p][30:0], 1'b0} >= CLK_HZ) begin
          acc_ff[p]   <= acc_ff[p] + {inc[p][30:0], 1'b0} - CLK_HZ;
          gbclk_ff[p] <= ~gbclk_ff[p];
          if (gbclk_ff[p]) begin
            // Falling edge: advance bit and frame clock
            if (gbit_ff[p] == frame_bits(mode_ff[p].tdm) - 10'h001) begin
              gbit_ff[p] <= '0;
              glr_ff[p]  <= mode_ff[p].lrclk_pos;
            end else begin
              gbit_ff[p] <= gbit_ff[p] + 10'h001;
              if (mode_ff[p].pulse_sync) begin
                glr_ff[p] <= ~mode_ff[p].lrclk_pos;
              end else if (gbit_ff[p] + 10'h001 == (frame_bits(mode_ff[p].tdm) >> 1)) begin
                glr_ff[p] <= ~mode_ff[p].lrclk_pos;
              end
            end
          end
        end else begin
          acc_ff[p] <= acc_ff[p] + {inc[p][30:0], 1'b0};
        end
      end
    end
  end

  // Master port n drives pin pair n; enable low while driving
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bpin_ff  <= '0;
      lpin_ff  <= '0;
      boe_n_ff <= '1;
      loe_n_ff <= '1;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        bpin_ff[p]  <= gen_ok[p] & (gbclk_ff[p] ^ mode_ff[p].bclk_pos);
        lpin_ff[p]  <= gen_ok[p] & glr_ff[p];
        boe_n_ff[p] <= ~gen_ok[p];
        loe_n_ff[p] <= ~gen_ok[p];
      end
    end
  end

  // ==========================================================================
  // Deserialiser
  // Clock selection, edge detection and slot position per port
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      e_now[p]  = 1'b0;
      lr_now[p] = lr_last_ff[p];
      if (is_master[p]) begin
        e_now[p]  = gen_ok[p] & gbclk_ff[p];
        lr_now[p] = glr_ff[p];
      end else if ((mode_ff[p].domain <= DOM_LAST_SLAVE) && avail[mode_ff[p].domain]) begin
        e_now[p]  = bclk_s2_ff[mode_ff[p].domain] ^ mode_ff[p].bclk_pos;
        lr_now[p] = lr_filt_ff[mode_ff[p].domain];
      end
      rise[p]   = e_now[p] & ~e_prev_ff[p];
      fstart[p] = (lr_now[p] == mode_ff[p].lrclk_pos) && (lr_last_ff[p] != mode_ff[p].lrclk_pos);
      fhalf[p]  = !mode_ff[p].pulse_sync && (mode_ff[p].tdm == SAI_TDM2)
                  && (lr_now[p] != mode_ff[p].lrclk_pos) && (lr_last_ff[p] == mode_ff[p].lrclk_pos);
      if (fstart[p]) begin
        nxt_pos[p]  = '0;
        nxt_chan[p] = '0;
      end else if (fhalf[p]) begin
        nxt_pos[p]  = '0;
        nxt_chan[p] = 5'h01;
      end else if (pos_ff[p] == slot_last(mode_ff[p].tdm)) begin
        nxt_pos[p]  = '0;
        nxt_chan[p] = chan_ff[p] + 5'h01;
      end else begin
        nxt_pos[p]  = pos_ff[p] + 5'h01;
        nxt_chan[p] = chan_ff[p];
      end
      in_win[p]    = (nxt_pos[p] >= msb_delay(mode_ff[p].msb))
                     && ({1'b0, nxt_pos[p]} < {1'b0, msb_delay(mode_ff[p].msb)}
                                              + {1'b0, word_len(mode_ff[p].wl)});
      last_bit[p]  = in_win[p] && ({1'b0, nxt_pos[p]} + 6'h01
                     == {1'b0, msb_delay(mode_ff[p].msb)} + {1'b0, word_len(mode_ff[p].wl)});
      nxt_shift[p] = {shift_ff[p][SAMPLE_W-2:0], sd_s2_ff[p]};
    end
  end

  // Shift data bits on the capture edge and latch finished words
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      e_prev_ff  <= '0;
      lr_last_ff <= '1; // Idle level of a reset-mode frame clock, so the first edge counts
      framed_ff  <= '0;
      pend_ff    <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        pos_ff[p]   <= '0;
        chan_ff[p]  <= '0;
        shift_ff[p] <= '0;
        word_ff[p]  <= '0;
        wchan_ff[p] <= '0;
      end
    end else begin
      e_prev_ff <= e_now;
      for (int p = 0; p < NUM_PORTS; p++) begin
        // Arbiter takes the word; a new one sets after the clear
        if (pend_ff[p] && (rr_ff == PORT_W'(p))) begin
          pend_ff[p] <= 1'b0;
        end
        if (mode_wr[p]) begin
          framed_ff[p] <= 1'b0;
        end
        if (rise[p]) begin
          lr_last_ff[p] <= lr_now[p];
          pos_ff[p]     <= nxt_pos[p];
          chan_ff[p]    <= nxt_chan[p];
          if (fstart[p]) begin
            framed_ff[p] <= 1'b1; // set wins over the clear of a mode write
          end
          if (in_win[p]) begin
            shift_ff[p] <= nxt_shift[p];
          end
          if (last_bit[p] && (framed_ff[p] || fstart[p])
              && (nxt_chan[p] < max_chan(mode_ff[p].tdm))) begin
            // Left-align 16 and 20-bit words in the 24-bit sample
            word_ff[p]  <= nxt_shift[p] << (5'h18 - word_len(mode_ff[p].wl));
            wchan_ff[p] <= nxt_chan[p];
            pend_ff[p]  <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Sample output
  // Round-robin scan hands out one pending word per cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rr_ff     <= '0;
      sample_ff <= '0;
      svalid_ff <= 1'b0;
    end else begin
      rr_ff     <= (rr_ff == PORT_W'(NUM_PORTS - 1)) ? '0 : rr_ff + 4'h1;
      svalid_ff <= pend_ff[rr_ff];
      if (pend_ff[rr_ff]) begin
        sample_ff.port <= rr_ff;
        sample_ff.chan <= wchan_ff[rr_ff];
        sample_ff.data <= word_ff[rr_ff];
      end
    end
  end

  // Outputs straight from flops
  assign reg_rdata_o        = rdata_ff;
  assign bclk_pin_o         = bpin_ff;
  assign lrclk_pin_o        = lpin_ff;
  assign bclk_pin_oe_n_o    = boe_n_ff;
  assign lrclk_pin_oe_n_o   = loe_n_ff;
  assign clk_pad_out_side_o = padmux_ff;
  assign sample_o           = sample_ff;
  assign sample_valid_o     = svalid_ff;

endmodule : sai_rx_top

`default_nettype wire

// ===== verification/sai_rx_props.sv
// Checker: register port and clock pin behaviour of the serial audio input block
`timescale 1ns/100ps
`default_nettype none
module sai_rx_props
  import sai_pkg::*;
(
  // Watched ports
  input wire logic                           core_clk_i,
  input wire logic                           sys_rst_i,
  input wire logic [sai_pkg::ADDR_W-1:0]     reg_addr_i,
  input wire logic [sai_pkg::DATA_W-1:0]     reg_wdata_i,
  input wire logic                           reg_wr_i,
  input wire logic                           reg_rd_i,
  input wire logic [sai_pkg::DATA_W-1:0]     reg_rdata_o,
  input wire logic [sai_pkg::NUM_PORTS-1:0]  bclk_pin_o,
  input wire logic [sai_pkg::NUM_PORTS-1:0]  bclk_pin_oe_n_o,
  input wire logic [sai_pkg::NUM_PORTS-1:0]  lrclk_pin_oe_n_o,
  input wire logic [sai_pkg::NUM_ASSIGN-1:0] clk_pad_out_side_o,
  input wire sai_pkg::sai_sample_s           sample_o,
  input wire logic                           sample_valid_o
);
  logic mode_wr_ff;

  // Marks that software has written a port mode word since reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      mode_wr_ff <= 1'b0;
    else if (reg_wr_i && reg_addr_i[17:6] == 12'hE00)
      mode_wr_ff <= 1'b1;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================================
  // Register access steps
  sequence rd_of(logic [15:0] idx);
    reg_rd_i && reg_addr_i == {idx, 2'b00};
  endsequence
  sequence pad_wr;
    reg_wr_i && reg_addr_i == {REG_PADMUX_IDX, 2'b00};
  endsequence

  dejit_rsv_a: assert property (rd_of(REG_DEJIT_IDX) |=> reg_rdata_o[15:6] == 10'h000)
    else $error("dejitter reserved bits not zero");
  pad_rd_a: assert property (rd_of(REG_PADMUX_IDX) |=>
    reg_rdata_o == {10'h000, $past(clk_pad_out_side_o)}) else $error("pad mux readback wrong");
  pad_wr_a: assert property (pad_wr |=> {10'h000, clk_pad_out_side_o} ==
    ($past(reg_wdata_i) & 16'h003F)) else $error("pad mux write lost");
  pad_hold_a: assert property (!pad_wr |=> $stable(clk_pad_out_side_o))
    else $error("pad mux changed without write");
  unmap_rd_a: assert property (reg_rd_i && reg_addr_i[1:0] != 2'h0 |=> reg_rdata_o == 16'h0000)
    else $error("unaligned read not zero");
  pin_idle_a: assert property ((bclk_pin_o & bclk_pin_oe_n_o) == 9'h000)
    else $error("bit clock level while not driving");
  slave_rst_a: assert property (!mode_wr_ff |-> &bclk_pin_oe_n_o && &lrclk_pin_oe_n_o)
    else $error("pin driven in reset slave mode");
  port_rng_a: assert property (sample_valid_o |-> sample_o.port < 4'h9)
    else $error("sample from unknown port");
endmodule : sai_rx_props

bind sai_rx_top sai_rx_props sai_rx_props_i (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bclk_pin_o, .bclk_pin_oe_n_o, .lrclk_pin_oe_n_o,
  .clk_pad_out_side_o, .sample_o, .sample_valid_o);
`default_nettype wire

// ===== verification/sai_codec_model.sv
// Partner model: external codec sending stereo frames on one clock pair
`timescale 1ns/100ps
`default_nettype none
module sai_codec_model (
  // Clock pair and data line toward the block
  output logic bclk_o,
  output logic lrclk_o,
  output logic sdata_o
);
  // Idle levels: bit clock low, frame clock high
  initial begin
    bclk_o  = 1'b0;
    lrclk_o = 1'b1;
    sdata_o = 1'b0;
  end

  // One frame of two 24-bit words, MSB one bit after the frame edge
  // Stereo I2S only, never packed or delay-16, bit clock far below the cap
  task automatic send_frame(input logic [23:0] left, input logic [23:0] right);
    int s;
    for (int i = 0; i < 64; i++) begin
      s       = i % 32;
      bclk_o  = 1'b0;
      lrclk_o = (i >= 32);
      if (s >= 1 && s <= 24)
        sdata_o = (i >= 32) ? right[24 - s] : left[24 - s];
      else
        sdata_o = ~sdata_o;
      #62.5;
      bclk_o = 1'b1;
      #62.5;
    end
    bclk_o  = 1'b0;     // Bit clock stands still between frames
    sdata_o = ~sdata_o;
  endtask : send_frame
endmodule : sai_codec_model
`default_nettype wire

// ===== verification/sai_rx_top_test.sv
// Testbench: registers, pad mux, domain selector and stereo capture
`timescale 1ns/100ps
`default_nettype none
module sai_rx_top_test;
  import sai_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [8:0] serial_audio_input_line_i, bclk_pin_i, lrclk_pin_i, bclk_pin_o, lrclk_pin_o;
  logic [8:0] bclk_pin_oe_n_o, lrclk_pin_oe_n_o;
  logic [5:0] clk_pad_out_side_o;
  sai_sample_s sample_o;
  logic sample_valid_o, bclk, lrclk, sdata;
  logic [8:0] dead_pairs = 9'h040;
  logic [8:0] line_mask = 9'h0A5;
  logic [31:0] seed = 32'hFE6E;
  logic [23:0] got [9][2];
  int cnt [9];
  int err_total = 0;
  int checks_done = 0;

  // Codec clocks fan out to every pair; one pair has no bit clock
  assign bclk_pin_i = {9{bclk}} & ~dead_pairs;
  assign lrclk_pin_i = {9{lrclk}};
  assign serial_audio_input_line_i = {9{sdata}} ^ line_mask;
  always #2.5 core_clk_i = ~core_clk_i;

  sai_codec_model sai_codec_model_i (.bclk_o(bclk), .lrclk_o(lrclk), .sdata_o(sdata));
  sai_rx_top sai_rx_top_i (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .serial_audio_input_line_i, .bclk_pin_i, .lrclk_pin_i, .bclk_pin_o,
    .lrclk_pin_o, .bclk_pin_oe_n_o, .lrclk_pin_oe_n_o, .clk_pad_out_side_o, .sample_o,
    .sample_valid_o);

  // Collects every sample word by port and channel
  always @(posedge core_clk_i) begin
    if (sample_valid_o === 1'b1 && sample_o.port < 4'h9) begin
      got[sample_o.port][sample_o.chan[0]] = sample_o.data;
      cnt[sample_o.port]++;
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= {idx, 2'b00};
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] idx, input logic [15:0] exp);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= {idx, 2'b00};
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 check({16'h0000, reg_rdata_o}, {16'h0000, exp});
  endtask : reg_rd

  // Sends one random frame and checks which ports delivered what
  task automatic run_frame(input logic [8:0] live);
    logic [23:0] w [2];
    w[0] = 24'(xs());
    w[1] = 24'(xs());
    cnt = '{default: 0};
    sai_codec_model_i.send_frame(w[0], w[1]);
    repeat (40) @(posedge core_clk_i);
    for (int p = 0; p < 9; p++) begin
      check(32'(cnt[p]), live[p] ? 32'h2 : 32'h0);
      for (int c = 0; c < 2 && live[p]; c++)
        check({8'h00, got[p][c]}, {8'h00, line_mask[p] ? ~w[c] : w[c]});
    end
  endtask : run_frame

  task automatic print_verdict();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Watchdog against a hung run
  initial begin
    #60000;
    err_total++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [15:0] r;
    int n;
    logic b;
    logic [8:0] k;
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    reg_rd(REG_DEJIT_IDX, 16'h0008);
    reg_rd(REG_PADMUX_IDX, 16'h0000);
    reg_rd(16'h0100, 16'h0000);
    // Misaligned read of a mapped word returns zero
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= {REG_DEJIT_IDX, 2'b01};
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 check({16'h0000, reg_rdata_o}, 32'h0);
    for (int i = 0; i < 9; i++)
      reg_rd(REG_MODE0_IDX + 16'(i), {2'h0, 4'(i), 10'h000});
    reg_wr(REG_DEJIT_IDX, 16'hFFFF);
    reg_rd(REG_DEJIT_IDX, 16'h003F);
    for (int i = 0; i < 8; i++) begin
      r = 16'(xs());
      reg_wr(REG_PADMUX_IDX, r);
      reg_rd(REG_PADMUX_IDX, r & 16'h003F);
      check({26'h0, clk_pad_out_side_o}, {16'h0000, r & 16'h003F});
    end
    reg_wr(REG_PADMUX_IDX, 16'h0000);
    reg_wr(REG_DEJIT_IDX, 16'h0008);
    run_frame(9'h1BF);
    reg_wr(REG_DEJIT_IDX, 16'h0000);
    reg_wr(REG_PADMUX_IDX, 16'h0001);
    reg_wr(REG_MODE0_IDX + 16'h6, 16'h0800);
    run_frame(9'h1F7);
    // Port 0 master at base rate; port 1 asks for a TDM16 quad rate above the cap
    reg_wr(REG_MODE0_IDX, 16'hA400);
    reg_wr(REG_MODE0_IDX + 16'h1, 16'hAC03);
    repeat (2) @(posedge core_clk_i);
    #1 check({23'h0, bclk_pin_oe_n_o}, 32'h1FE);
    check({23'h0, lrclk_pin_oe_n_o}, 32'h1FE);
    n = 0;
    k = '0;
    // 3.072 MHz bit clock toggles 12 or 13 times in 2 us
    for (int i = 0; i < 400; i++) begin
      b = bclk_pin_o[0];
      @(posedge core_clk_i);
      #1 n += int'(bclk_pin_o[0] != b);
      k |= (bclk_pin_o | lrclk_pin_o) & 9'h1FE;
    end
    check(32'(n >= 12 && n <= 13), 32'h1);
    check({23'h0, k}, 32'h0);
    print_verdict();
  end
endmodule : sai_rx_top_test
`default_nettype wire
